// File: rtl/gnc_pkg.sv
// constants, field layouts and carrier types of the gateway network command unit
// Behaviour
// - after node number write, connection may take up to ten seconds
// - node select holds node number in bits 3:0, upper bits unused
// - command bit 15 removes the node in node select
// - command bit 13 requests configuration and payload from selected node
// - command bit 12 pushes all alarm registers to selected node
// - command bit 11 fetches alarm registers from selected node
// - command bit 10 copies gateway page alarm configuration to remote node
// - bit 6 saves flash, bit 7 software reset, bit 4 clears diagnostics
// - command bit 5 runs flash checksum test against factory value
// - command bit 3 restores factory register settings
// - command bit 1 starts update of selected node, except spectral alarms
// - network number: bits 15:0 network_number, both bytes writable, default 0x1234
// - page identity reads zero when page manages no node
// - connected page identity bits 15:8 read fixed marker code
// - connected page identity bits 7:0 read assigned node number
// - signal strength reads 16-bit two's complement, 1 dBm per step
// - node pages 1..6 read zero until a node connects there
package gnc_pkg;

  // register byte addresses (low byte of each 16-bit word)
  localparam logic [6:0] ADDR_PAGE   = 7'h00;
  localparam logic [6:0] ADDR_NET    = 7'h02;
  localparam logic [6:0] ADDR_IDENT  = 7'h06;
  localparam logic [6:0] ADDR_GATEWAY_SIGNAL_STRENGTH = 7'h0a;
  localparam logic [6:0] ADDR_CMD    = 7'h12;
  localparam logic [6:0] ADDR_SEL    = 7'h14;
  localparam logic [6:0] ADDR_NODE_SIGNAL_STRENGTH = 7'h5a;

  // command bit positions
  localparam int CMD_ADD       = 0;
  localparam int CMD_UPDATE    = 1;
  localparam int CMD_FACTORY   = 3;
  localparam int CMD_CLRDIAG   = 4;
  localparam int CMD_FLASHTEST = 5;
  localparam int CMD_SAVE      = 6;
  localparam int CMD_SWRESET   = 7;
  localparam int CMD_DROP      = 8;
  localparam int CMD_ALMCOPY   = 10;
  localparam int CMD_ALMFETCH  = 11;
  localparam int CMD_ALMPUSH   = 12;
  localparam int CMD_REQCFG    = 13;
  localparam int CMD_REMOVE    = 15;

  // frame layout: write flag, byte address, data byte
  localparam int FRAME_BITS = 16;
  localparam int FRAME_WR   = 15;
  localparam int FRAME_AHI  = 14;
  localparam int FRAME_ALO  = 8;

  // reset values and ranges
  localparam logic [15:0] NET_RESET  = 16'h1234;
  localparam logic [3:0]  SEL_RESET  = 4'h0;
  localparam logic [7:0]  PAGE_RESET = 8'h00;
  localparam logic [3:0]  NODE_MAX   = 4'h6;
  localparam int          NODE_PAGES = 6;
  localparam logic [7:0]  PAGE_GW    = 8'h00;

  // connection marker code; value is arbitrary
  localparam logic [7:0] IDENT_MARKER = 8'h5c;

  // connection window: time in seconds and derived cycle count
  localparam longint CLK_HZ         = 100_000_000;
  localparam longint CONNECT_TIME_S = 10;
  localparam int unsigned CONNECT_CYCLES = 32'(CONNECT_TIME_S * CLK_HZ);

  // one-cycle action pulses towards the radio / flash controller
  typedef struct packed {
    logic [3:0] node;
    logic       connectStart;
    logic       update;
    logic       factoryRestore;
    logic       clearDiag;
    logic       flashTest;
    logic       saveFlash;
    logic       softReset;
    logic       dropNode;
    logic       alarmCopy;
    logic       alarmFetch;
    logic       alarmPush;
    logic       requestConfig;
    logic       removeNode;
  } gnc_cmd_s;

  // link status reported by the radio side
  typedef struct packed {
    logic [NODE_PAGES-1:0]       connected;
    logic [NODE_PAGES-1:0][7:0]  assignedNode;
    logic [NODE_PAGES-1:0][15:0] nodeRssi;
    logic [15:0]                 gwRssi;
    logic                        connectDone;
  } gnc_link_s;

endpackage

// File: rtl/gnc_pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module gnc_pin_sync
  import gnc_pkg::*;
#(
  parameter int         WIDTH     = 3,
  parameter logic [2:0] RESET_VAL = 3'h0
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } gnc_sync_s;

  gnc_sync_s state_q;
  gnc_sync_s state_d;

  // stage one feeds only stage two; the filter looks at stages two and three
  always_comb begin
    state_d    = state_q;
    state_d.s1 = pinIn;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (state_q.s2[i] == state_q.s3[i]) begin
        state_d.level[i] = state_q.s3[i];
      end
    end
  end

  // idle levels at reset keep a stray edge from appearing at release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= {4{RESET_VAL[WIDTH-1:0]}};
    end else begin
      state_q <= state_d;
    end
  end

  assign pinOut = state_q.level;

endmodule
`default_nettype wire

// File: rtl/gnc_command_unit.sv
// gateway command interpreter: serial host port, page 0 registers and node pages
`timescale 1ns/1ps
`default_nettype none
module gnc_command_unit
  import gnc_pkg::*;
#(
  parameter int unsigned CONNECT_LIMIT = CONNECT_CYCLES
) (
  input  wire logic      sys_clk,
  input  wire logic      resetn,
  input  wire logic      spiSclk,
  input  wire logic      spiCsN,
  input  wire logic      spiMosi,
  output logic           spiMiso,
  input  wire gnc_link_s linkIn,
  output gnc_cmd_s       cmdOut,
  output logic           connectBusy,
  output logic           connectTimeout
);

  typedef struct packed {
    logic [7:0]  page;
    logic [15:0] net;
    logic [3:0]  sel;
    logic        addArmed;
    logic        connBusy;
    logic [31:0] connCnt;
    logic        connTimeout;
    logic        sclkPrev;
    logic        csPrevN;
    logic [15:0] shiftIn;
    logic [4:0]  bitCnt;
    logic [15:0] shiftOut;
    logic [15:0] readData;
    logic        misoBit;
    gnc_cmd_s    cmd;
  } gnc_state_s;

  // last serial bit, final connect count and the pins' idle levels
  localparam logic [4:0]  LAST_BIT   = 5'(FRAME_BITS - 1);
  localparam logic [31:0] CONN_LAST  = 32'(CONNECT_LIMIT - 1);
  localparam logic [2:0]  PIN_IDLE   = 3'h6;

  // register bank, its next value and the filtered pin levels
  gnc_state_s state_q;
  gnc_state_s state_d;
  logic [2:0] pinLvl;
  logic       sclkLvl;
  logic       csLvlN;
  logic       mosiLvl;

  // host pins come from another clock domain
  gnc_pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (PIN_IDLE)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .pinIn   ({spiSclk, spiCsN, spiMosi}),
    .pinOut  (pinLvl)
  );

  // pin order inside the synchroniser: clock, select, data
  assign sclkLvl = pinLvl[2];
  assign csLvlN  = pinLvl[1];
  assign mosiLvl = pinLvl[0];

  // word address of a byte address: both bytes of a register share it
  function automatic logic [6:0] wordAddr(input logic [6:0] a);
    wordAddr = {a[6:1], 1'b0};
  endfunction

  // node number in range for per-node commands
  function automatic logic nodeOk(input logic [3:0] n);
    nodeOk = (n <= NODE_MAX);
  endfunction

  // replace one byte of a word; an odd byte address picks the upper byte
  function automatic logic [15:0] mergeByte(
    input logic [15:0] old,
    input logic [7:0]  data,
    input logic        hi
  );
    mergeByte = hi ? {data, old[7:0]} : {old[15:8], data};
  endfunction

  // one pulse per command bit written as 1, except add (bit 0); actions aimed at a node also need it in range
  function automatic gnc_cmd_s pulseVec(
    input logic [15:0] bits,
    input logic        ok
  );
    pulseVec                = '0;
    pulseVec.update         = bits[CMD_UPDATE] && ok;
    pulseVec.factoryRestore = bits[CMD_FACTORY];
    pulseVec.clearDiag      = bits[CMD_CLRDIAG];
    pulseVec.saveFlash      = bits[CMD_SAVE];
    pulseVec.softReset      = bits[CMD_SWRESET];
    pulseVec.flashTest      = bits[CMD_FLASHTEST];
    pulseVec.dropNode       = bits[CMD_DROP] && ok;
    pulseVec.alarmCopy      = bits[CMD_ALMCOPY] && ok;
    pulseVec.alarmFetch     = bits[CMD_ALMFETCH] && ok;
    pulseVec.alarmPush      = bits[CMD_ALMPUSH] && ok;
    pulseVec.requestConfig  = bits[CMD_REQCFG] && ok;
    pulseVec.removeNode     = bits[CMD_REMOVE] && ok;
  endfunction

  // read decode for the selected page
  function automatic logic [15:0] readReg(
    input logic [7:0]  page,
    input logic [6:0]  addr,
    input logic [15:0] net,
    input logic [3:0]  sel,
    input gnc_link_s   link
  );
    logic [2:0] idx;
    // unmapped words and pages above six read zero
    readReg = 16'h0000;
    idx     = 3'h0;
    if (wordAddr(addr) == ADDR_PAGE) begin
      readReg = {8'h00, page};
    end else if (page == PAGE_GW) begin
      // page 0 manages no node, so its identity word stays zero
      unique case (wordAddr(addr))
        ADDR_NET:    readReg = net;
        ADDR_SEL:    readReg = {12'h000, sel};
        ADDR_GATEWAY_SIGNAL_STRENGTH: readReg = link.gwRssi;
        default:     readReg = 16'h0000;
      endcase
    end else if (page <= 8'(NODE_PAGES)) begin
      idx = 3'(page - 8'h01);
      if (link.connected[idx]) begin
        unique case (wordAddr(addr))
          ADDR_IDENT:  readReg = {IDENT_MARKER, link.assignedNode[idx]};
          ADDR_NODE_SIGNAL_STRENGTH: readReg = link.nodeRssi[idx];
          default:     readReg = 16'h0000;
        endcase
      end else begin
        readReg = 16'h0000;
      end
    end
  endfunction

  // serial framing, register writes, command pulses and connect timer
  always_comb begin
    logic [15:0] word;
    logic [6:0]  addr;
    logic [7:0]  data;
    logic [15:0] bits;
    logic        hiByte;
    logic        okNode;
    // frame fields as they will stand once this bit is shifted in
    word   = {state_q.shiftIn[14:0], mosiLvl};
    addr   = word[FRAME_AHI:FRAME_ALO];
    data   = word[7:0];
    hiByte = addr[0];
    bits   = 16'h0000;
    okNode = nodeOk(state_q.sel);

    // everything holds unless changed below; pulses and the timeout last one cycle
    state_d             = state_q;
    state_d.sclkPrev    = sclkLvl;
    state_d.csPrevN     = csLvlN;
    state_d.cmd         = '0;
    state_d.cmd.node    = state_q.sel;
    state_d.connTimeout = 1'b0;

    // frame start loads the answer to the previous read request
    if (state_q.csPrevN && !csLvlN) begin
      state_d.bitCnt   = 5'h00;
      state_d.shiftOut = state_q.readData;
    end

    // a frame cut short by deselect is dropped, and the data line parks low between frames
    if (!state_q.csPrevN && csLvlN) begin
      state_d.bitCnt  = 5'h00;
      state_d.misoBit = 1'b0;
    end

    // output changes on the falling clock edge, host samples on rising
    if (!csLvlN && state_q.sclkPrev && !sclkLvl) begin
      state_d.misoBit  = state_q.shiftOut[15];
      state_d.shiftOut = {state_q.shiftOut[14:0], 1'b0};
    end

    // input sampled on the rising clock edge
    if (!csLvlN && !state_q.sclkPrev && sclkLvl) begin
      state_d.shiftIn = word;
      state_d.bitCnt  = state_q.bitCnt + 5'h01;
      if (state_q.bitCnt == LAST_BIT) begin
        state_d.bitCnt = 5'h00;
        if (!word[FRAME_WR]) begin
          state_d.readData = readReg(state_q.page, addr, state_q.net, state_q.sel, linkIn);
        end else if (wordAddr(addr) == ADDR_PAGE) begin
          if (!hiByte) begin
            state_d.page = data;
          end
        end else if (state_q.page == PAGE_GW) begin
          unique case (wordAddr(addr))
            ADDR_NET: begin
              state_d.net = mergeByte(state_q.net, data, hiByte);
            end
            ADDR_SEL: begin
              if (!hiByte) begin
                state_d.sel = data[3:0];
                if (state_q.addArmed && nodeOk(data[3:0])) begin
                  state_d.addArmed         = 1'b0;
                  state_d.cmd.node         = data[3:0];
                  state_d.cmd.connectStart = 1'b1;
                  state_d.connBusy         = 1'b1;
                  state_d.connCnt          = 32'h0000_0000;
                end
              end
            end
            ADDR_CMD: begin
              bits = mergeByte(16'h0000, data, hiByte);
            end
            default: begin
              bits = 16'h0000;
            end
          endcase
        end
      end
    end

    if (bits[CMD_ADD]) begin
      state_d.addArmed = 1'b1;
    end
    // ones in the command word become pulses; node and start fields stay as set above
    state_d.cmd = gnc_cmd_s'(state_d.cmd | pulseVec(bits, okNode));

    // factory values return to this block's network number and node select too; the page register keeps its value
    if (bits[CMD_FACTORY]) begin
      state_d.net = NET_RESET;
      state_d.sel = SEL_RESET;
    end

    // ten-second connection window; a new start wins over ending
    if (state_q.connBusy && !state_d.cmd.connectStart) begin
      if (linkIn.connectDone) begin
        state_d.connBusy = 1'b0;
      end else if (state_q.connCnt == CONN_LAST) begin
        state_d.connBusy    = 1'b0;
        state_d.connTimeout = 1'b1;
      end else begin
        state_d.connCnt = state_q.connCnt + 32'h0000_0001;
      end
    end

    // software reset returns registers and aborts a pending add
    if (bits[CMD_SWRESET]) begin
      state_d.page     = PAGE_RESET;
      state_d.net      = NET_RESET;
      state_d.sel      = SEL_RESET;
      state_d.addArmed = 1'b0;
      state_d.connBusy = 1'b0;
      state_d.connCnt  = 32'h0000_0000;
    end
  end

  // single register bank; reset values are constants only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q          <= '0;
      state_q.page     <= PAGE_RESET;
      state_q.net      <= NET_RESET;
      state_q.sel      <= SEL_RESET;
      state_q.sclkPrev <= 1'b1;
      state_q.csPrevN  <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs come straight from flip-flops, so no glitch reaches the pins
  assign spiMiso        = state_q.misoBit;
  assign cmdOut         = state_q.cmd;
  assign connectBusy    = state_q.connBusy;
  assign connectTimeout = state_q.connTimeout;

endmodule
`default_nettype wire

// File: verif/gnc_checker.sv
// concurrent checks on the command unit's ports, bound to every instance
`timescale 1ns/1ps
`default_nettype none
module gnc_checker
  import gnc_pkg::*;
#(
  parameter int unsigned CONNECT_LIMIT = 50
) (
  input  wire logic      sys_clk,
  input  wire logic      resetn,
  input  wire gnc_link_s linkIn,
  input  wire gnc_cmd_s  cmdOut,
  input  wire logic      connectBusy,
  input  wire logic      connectTimeout
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  logic [31:0] busyCnt_q;

  // age of the open window; a fresh start restarts it, so the bound holds per start
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busyCnt_q <= '0;
    end else begin
      busyCnt_q <= (connectBusy && !cmdOut.connectStart) ? busyCnt_q + 32'h1 : '0;
    end
  end

  // window steps: opened by a start, closed by the radio's confirmation
  sequence openSeq;
    connectBusy ##1 (connectBusy || $past(linkIn.connectDone));
  endsequence
  sequence closeSeq;
    linkIn.connectDone && connectBusy && !cmdOut.connectStart;
  endsequence

  // connect window, node range and closing conditions
  start_busy_a: assert property (cmdOut.connectStart |-> openSeq)
    else $error("start did not open the window");
  busy_rise_a: assert property ($rose(connectBusy) |-> cmdOut.connectStart)
    else $error("window opened without a start");
  start_node_a: assert property (cmdOut.connectStart |-> cmdOut.node <= NODE_MAX)
    else $error("start with node above range");
  node_cmd_a: assert property ((|{cmdOut.update, cmdOut.dropNode, cmdOut.alarmFetch, cmdOut.alarmPush,
    cmdOut.alarmCopy, cmdOut.requestConfig, cmdOut.removeNode}) |-> cmdOut.node <= NODE_MAX)
    else $error("node command with node above range");
  done_close_a: assert property (closeSeq |-> ##[1:2] !connectBusy)
    else $error("window stayed open after confirmation");
  timeout_cause_a: assert property (connectTimeout |-> $past(connectBusy))
    else $error("timeout without an open window");
  timeout_close_a: assert property (connectTimeout |-> ##[0:1] !connectBusy)
    else $error("window open after timeout");
  busy_bound_a: assert property (busyCnt_q <= CONNECT_LIMIT + 2)
    else $error("window open too long");
  swreset_close_a: assert property (cmdOut.softReset |-> ##[0:1] !connectBusy)
    else $error("window open after software reset");
endmodule

bind gnc_command_unit gnc_checker #(.CONNECT_LIMIT(CONNECT_LIMIT)) chk (
  .sys_clk(sys_clk), .resetn(resetn), .linkIn(linkIn), .cmdOut(cmdOut),
  .connectBusy(connectBusy), .connectTimeout(connectTimeout));
`default_nettype wire

// File: verif/gnc_host_model.sv
// host serial master model: mode 3 frames of 16 bits, msb first
`timescale 1ns/1ps
`default_nettype none
module gnc_host_model
  import gnc_pkg::*;
#(
  parameter int HALF = 5
) (
  input  wire logic sys_clk,
  input  wire logic spiMiso,
  output var logic  spiSclk,
  output var logic  spiCsN,
  output var logic  spiMosi
);
  // idle: clock parked high, device deselected
  initial begin
    spiSclk = 1'b1;
    spiCsN  = 1'b1;
    spiMosi = 1'b0;
  end

  // one frame; HALF clocks per phase keeps each phase well above the sync latency
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(negedge sys_clk) spiCsN = 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      repeat (HALF) @(negedge sys_clk);
      spiSclk = 1'b0;
      spiMosi = w[i];
      repeat (HALF) @(negedge sys_clk);
      r[i] = spiMiso;
      spiSclk = 1'b1;
    end
    repeat (HALF) @(negedge sys_clk);
    spiCsN  = 1'b1;
    spiMosi = ~spiMosi; // released line never shows the last bit
    repeat (HALF) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench: register map, command pulses and the connect window
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top
  import gnc_pkg::*;
;
  localparam int LIMIT = 50;
  logic        sys_clk, resetn, spiSclk, spiCsN, spiMosi, spiMiso, connectBusy, connectTimeout, timedOut;
  logic [12:0] pulses;
  logic [3:0]  nodeSeen;
  logic [15:0] rdat;
  gnc_link_s   linkIn;
  gnc_cmd_s    cmdOut;
  int          failures, check_count, seed, net, sel, node;
  int          cbit[11] = '{1, 3, 4, 5, 6, 8, 10, 11, 12, 13, 15};
  int          pos[11]  = '{11, 10, 9, 8, 7, 5, 4, 3, 2, 1, 0};

  gnc_command_unit #(.CONNECT_LIMIT(LIMIT)) DUT (.sys_clk(sys_clk), .resetn(resetn), .spiSclk(spiSclk),
    .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .linkIn(linkIn), .cmdOut(cmdOut),
    .connectBusy(connectBusy), .connectTimeout(connectTimeout));
  gnc_host_model #(.HALF(5)) host (.sys_clk(sys_clk), .spiMiso(spiMiso), .spiSclk(spiSclk),
    .spiCsN(spiCsN), .spiMosi(spiMosi));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // collect pulses between frames, since they stand for one cycle only
  always @(posedge sys_clk) begin
    if (|cmdOut[12:0]) nodeSeen <= cmdOut.node;
    pulses <= pulses | cmdOut[12:0];
    if (connectTimeout) timedOut <= 1'b1;
  end

  // register accesses; a read needs a second frame to shift the word out
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    pulses = '0;
    host.xfer({1'b1, a, d}, rdat);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    host.xfer({1'b0, a, 8'h00}, rdat);
    host.xfer({1'b0, a, 8'h00}, rdat);
    `CHK(rdat, e)
  endtask

  // add sequence with an out-of-range node first, closed by radio or by expiry
  task automatic add(input int n, input logic done);
    wr(ADDR_CMD, 8'h01);
    repeat (50000) @(negedge sys_clk);
    wr(ADDR_SEL, 8'h07);
    `CHK(pulses, 13'h0)
    timedOut = 1'b0;
    wr(ADDR_SEL, 8'(n));
    `CHK({pulses[12], nodeSeen, connectBusy}, {1'b1, 4'(n), 1'b1})
    if (done) begin
      linkIn.connectDone = 1'b1;
      @(negedge sys_clk) linkIn.connectDone = 1'b0;
    end else
      repeat (LIMIT) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    `CHK({connectBusy, timedOut}, {1'b0, !done})
  endtask

  task automatic stop_test;
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial begin
    seed = 32'h4f6e;
    failures = 0;
    check_count = 0;
    resetn = 1'b0;
    linkIn = '0;
    pulses = '0;
    nodeSeen = '0;
    timedOut = 1'b0;
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (8) @(negedge sys_clk);
    rd(ADDR_NET, NET_RESET);
    rd(ADDR_SEL, 16'h0000);
    rd(ADDR_CMD, 16'h0000);
    rd(7'h20, 16'h0000);
    net = $random(seed);
    wr(ADDR_NET, net[7:0]);
    wr(ADDR_NET + 7'h1, net[15:8]);
    rd(ADDR_NET, net[15:0]);
    // each command bit alone except add and software reset, node taken from the select register
    for (int k = 0; k < 11; k++) begin
      sel = {$random(seed)} % 7;
      wr(ADDR_SEL, 8'(sel));
      wr(ADDR_CMD + 7'(cbit[k] / 8), 8'(1 << (cbit[k] % 8)));
      `CHK(pulses, 13'(1 << pos[k]))
      `CHK(nodeSeen, 4'(sel))
      if (cbit[k] == CMD_FACTORY) net = NET_RESET;
    end
    rd(ADDR_SEL, 16'(sel));
    rd(ADDR_NET, net[15:0]);
    // unused bits and an out-of-range select start nothing
    wr(ADDR_CMD, 8'h04);
    `CHK(pulses, 13'h0)
    wr(ADDR_CMD + 7'h1, 8'h42);
    `CHK(pulses, 13'h0)
    wr(ADDR_SEL, 8'h0f);
    wr(ADDR_CMD + 7'h1, 8'h80);
    `CHK(pulses, 13'h0)
    add({$random(seed)} % 7, 1'b1);
    add({$random(seed)} % 7, 1'b0);
    // radio reports page 2 connected, page 3 empty
    node = {$random(seed)} % 7;
    linkIn.connected = 6'b000010;
    linkIn.assignedNode[1] = 8'(node);
    // strengths kept within the host's reliable range, down to -92 dBm
    linkIn.nodeRssi[1] = 16'(-({$random(seed)} % 93));
    linkIn.gwRssi = 16'(-({$random(seed)} % 93));
    rd(ADDR_GATEWAY_SIGNAL_STRENGTH, linkIn.gwRssi);
    wr(ADDR_PAGE, 8'h02);
    rd(ADDR_IDENT, {IDENT_MARKER, 8'(node)});
    rd(ADDR_NODE_SIGNAL_STRENGTH, linkIn.nodeRssi[1]);
    wr(ADDR_PAGE, 8'h03);
    rd(ADDR_IDENT, 16'h0000);
    rd(ADDR_NODE_SIGNAL_STRENGTH, 16'h0000);
    wr(ADDR_NET, 8'h00);
    wr(ADDR_PAGE, 8'h00);
    rd(ADDR_NET, net[15:0]);
    // software reset brings the network number back
    wr(ADDR_NET, 8'h99);
    wr(ADDR_CMD, 8'h80);
    `CHK(pulses, 13'h040)
    rd(ADDR_NET, NET_RESET);
    stop_test;
  end

  // watchdog: two add waits of 50000 clocks plus about 70 frames of 171 clocks each
  initial begin
    repeat (150000) @(posedge sys_clk);
    failures++;
    stop_test;
  end
endmodule
`default_nettype wire
